// file: bench/lpws_seq_asserts.sv
// Port assertions for the wake supervisor.
`timescale 1ns/1ps
module lpws_seq_asserts
  import lpws_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic wake_irq,
  input wire logic power_up_clear_reset,
  input wire logic subsys_clk_run,
  input wire logic subsys_clk_overshoot,
  input wire logic subsys_clk_from_xtal,
  input wire logic sleeping,
  input wire logic core_reset_req,
  input wire logic irq
);
  // ****************************************************************
  // Run-length counters
  // ****************************************************************
  logic [7:0] ov_q;
  logic [3:0] sl_q;
  always_ff @(posedge core_clk) begin
    ov_q <= (reset || !subsys_clk_overshoot) ? 8'h00 : ov_q + 8'h01;
    sl_q <= (reset || !sleeping) ? 4'h0 : sl_q + {3'h0, sl_q != 4'hF};
  end
  default clocking dc @(posedge core_clk); endclocking
  default disable iff (reset);
  // ****************************************************************
  // Properties
  // ****************************************************************
  property p_rd_idle; !reg_rd |=> reg_rdata == 32'h0; endproperty
  property p_flag_set;
    reg_wr && reg_addr == ADDR_LOW_SV_CTRL ##2 reg_rd && reg_addr == ADDR_PM_FLAGS
      |=> reg_rdata[FLAG_LOW_SETTLE_BIT];
  endproperty
  property p_ov_max; subsys_clk_overshoot |-> 16'(ov_q) < OVERSHOOT_CYC; endproperty
  property p_ov_len;
    $fell(subsys_clk_overshoot) && !$past(reset) |-> 16'($past(ov_q)) == OVERSHOOT_CYC - 16'h1;
  endproperty
  property p_ov_run; subsys_clk_overshoot |-> subsys_clk_run; endproperty
  property p_ov_src; subsys_clk_overshoot |-> !subsys_clk_from_xtal; endproperty
  property p_ov_cause; $rose(subsys_clk_overshoot) |-> $past(sleeping) && $past(wake_irq); endproperty
  // An interrupt this early must not wake the core; only a clear or reset recovers it.
  property p_early;
    sleeping && wake_irq && !power_up_clear_reset && sl_q < 4'h5 |=> sleeping [*3];
  endproperty
  property p_rst_pulse; core_reset_req |=> !core_reset_req; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero");
  a_flag_set: assert property (p_flag_set) else $error("low settle flag not set");
  a_ov_max: assert property (p_ov_max) else $error("overshoot too long");
  a_ov_len: assert property (p_ov_len) else $error("overshoot length wrong");
  a_ov_run: assert property (p_ov_run) else $error("clock masked in overshoot");
  a_ov_src: assert property (p_ov_src) else $error("overshoot on crystal");
  a_ov_cause: assert property (p_ov_cause) else $error("overshoot without wake");
  a_early: assert property (p_early) else $error("early interrupt woke core");
  a_rst_pulse: assert property (p_rst_pulse) else $error("reset request too long");
  c_wake: cover property ($fell(subsys_clk_overshoot));
  c_stuck: cover property (sleeping && power_up_clear_reset);
  c_crr: cover property (core_reset_req);
endmodule : lpws_seq_asserts

bind lpws_seq lpws_seq_asserts chk_u (.core_clk(core_clk), .reset(reset),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .wake_irq(wake_irq), .power_up_clear_reset(power_up_clear_reset),
  .subsys_clk_run(subsys_clk_run), .subsys_clk_overshoot(subsys_clk_overshoot),
  .subsys_clk_from_xtal(subsys_clk_from_xtal), .sleeping(sleeping),
  .core_reset_req(core_reset_req), .irq(irq));

// file: bench/lpws_seq_test.sv
// Self-checking bench for the wake supervisor.
`timescale 1ns/1ps
module lpws_seq_test
  import lpws_pkg::*;
;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic wake_irq = 1'b0;
  logic power_up_clear_reset = 1'b0;
  logic [31:0] reg_rdata;
  logic subsys_clk_run, subsys_clk_overshoot, subsys_clk_from_xtal, sleeping;
  logic core_reset_req, irq;
  logic [31:0] d;
  int err_total = 0;
  int n_tests = 0;
  int cyc = 0;
  int ov_n = 0;
  int crr_n = 0;
  lpws_seq dut_u (.core_clk(core_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .wake_irq(wake_irq), .power_up_clear_reset(power_up_clear_reset),
    .subsys_clk_run(subsys_clk_run), .subsys_clk_overshoot(subsys_clk_overshoot),
    .subsys_clk_from_xtal(subsys_clk_from_xtal), .sleeping(sleeping),
    .core_reset_req(core_reset_req), .irq(irq));
  always #50 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc++;
    if (subsys_clk_overshoot === 1'b1) ov_n++;
    if (core_reset_req === 1'b1) crr_n++;
    if (cyc == 12000) begin
      err_total++;
      close_out();
    end
  end
  // ****************************************************************
  // Bus and compare tasks
  // ****************************************************************
  task automatic close_out;
    if (err_total == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : close_out
  task automatic wn(input int n);
    repeat (n) @(posedge core_clk);
  endtask : wn
  // A strobe still high from the call before gets one edge to drop, so it is never set twice at once.
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    if (reg_wr) @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe, so it is sampled just past that edge.
  task automatic rd(input logic [7:0] a);
    if (reg_wr) @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    @(posedge core_clk);
  endtask : rd
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic bchk(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask : bchk
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    chk(d, exp);
  endtask : rchk
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset;
    rchk(ADDR_CLK_CTRL, {30'h0, CLK_CTRL_RST});
    rchk(ADDR_PM_FLAGS, 32'h0);
    rchk(ADDR_IRQ_ENABLE, 32'h0);
    rchk(8'hFC, 32'h0);
    bchk(subsys_clk_run, 1'b1);
  endtask : t_reset
  task automatic t_settle;
    wr(ADDR_LOW_SV_CTRL, 32'h1);
    rchk(ADDR_PM_FLAGS, 32'h1);
    wn(12);
    rchk(ADDR_PM_FLAGS, 32'h1);
    wn(4);
    rchk(ADDR_PM_FLAGS, 32'h0);
    wr(ADDR_HIGH_SV_CTRL, 32'h0);
    wn(1400);
    rchk(ADDR_PM_FLAGS, 32'h2);
    wn(110);
    rchk(ADDR_PM_FLAGS, 32'h0);
    rd(ADDR_IRQ_STATUS);
    bchk(d[EV_SETTLED], 1'b1);
  endtask : t_settle
  task automatic t_core;
    crr_n = 0;
    wr(ADDR_CORE_LEVEL, 32'h1);
    wn(40);
    chk(crr_n, 32'h1);
    rd(ADDR_IRQ_STATUS);
    bchk(d[EV_CORE_RESET], 1'b1);
    wr(ADDR_LOW_SV_CTRL, 32'h0);
    wn(1510);
    wr(ADDR_CORE_LEVEL, 32'h2);
    wn(1600);
    chk(crr_n, 32'h1);
  endtask : t_core
  task automatic t_irq;
    wr(ADDR_IRQ_ENABLE, 32'h4);
    wn(1);
    bchk(irq, 1'b1);
    wr(ADDR_IRQ_ENABLE, 32'h0);
    wn(1);
    bchk(irq, 1'b0);
    wr(ADDR_IRQ_ENABLE, 32'h4);
    wr(ADDR_IRQ_CLEAR, 32'hF);
    wn(1);
    bchk(irq, 1'b0);
    rchk(ADDR_IRQ_STATUS, 32'h0);
    rchk(ADDR_IRQ_CLEAR, 32'h0);
    wr(ADDR_IRQ_ENABLE, 32'h1);
  endtask : t_irq
  task automatic t_wake(input logic [2:0] m, input logic [1:0] ctl, input int ov, input logic run);
    wr(ADDR_CLK_CTRL, {30'h0, ctl});
    wr(ADDR_LPM_ENTER, {29'h0, m});
    wn(1);
    bchk(sleeping, 1'b1);
    bchk(subsys_clk_from_xtal, ctl[CLK_SRC_XTAL_BIT]);
    bchk(subsys_clk_run, run);
    wn(12);
    ov_n = 0;
    wake_irq <= 1'b1;
    wn(1);
    wake_irq <= 1'b0;
    wn(100);
    chk(ov_n, ov);
    bchk(sleeping, 1'b0);
    bchk(irq, 1'b1);
    rd(ADDR_IRQ_STATUS);
    bchk(d[EV_WAKE_DONE], 1'b1);
    wr(ADDR_IRQ_CLEAR, 32'hF);
  endtask : t_wake
  task automatic t_fail;
    wr(ADDR_LPM_ENTER, {29'h0, LPM_CODE_2});
    wn(2);
    wake_irq <= 1'b1;
    wn(1);
    wake_irq <= 1'b0;
    wn(5);
    bchk(sleeping, 1'b1);
    rd(ADDR_IRQ_STATUS);
    bchk(d[EV_WAKE_FAIL], 1'b1);
    power_up_clear_reset <= 1'b1;
    wn(1);
    power_up_clear_reset <= 1'b0;
    wn(2);
    bchk(sleeping, 1'b0);
    wr(ADDR_LOW_SV_CTRL, 32'h0);
    wr(ADDR_LPM_ENTER, {29'h0, LPM_CODE_3});
    wn(20);
    wake_irq <= 1'b1;
    wn(1);
    wake_irq <= 1'b0;
    wn(5);
    bchk(sleeping, 1'b1);
    reset <= 1'b1;
    wn(2);
    reset <= 1'b0;
    wn(1);
    bchk(sleeping, 1'b0);
    rchk(ADDR_CLK_CTRL, {30'h0, CLK_CTRL_RST});
  endtask : t_fail
  initial begin
    wn(20);
    reset <= 1'b0;
    wn(1);
    t_reset();
    t_settle();
    t_core();
    t_irq();
    t_wake(LPM_CODE_3, 2'h1, 60, 1'b1);
    t_wake(LPM_CODE_4, 2'h3, 0, 1'b1);
    t_wake(LPM_CODE_2, 2'h1, 0, 1'b1);
    t_wake(LPM_CODE_4, 2'h0, 60, 1'b0);
    t_fail();
    close_out();
  end
endmodule : lpws_seq_test

// file: logic/lpws_pkg.sv
// Package with register map, field layout, states and timing counts of the wake supervisor.
package lpws_pkg;

  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int CLK_MHZ = 10;
  localparam int OVERSHOOT_US = 6;
  localparam int FULL_PERF_SETTLE_US = 2;
  localparam int NORMAL_SETTLE_US = 150;
  localparam int ENTRY_WINDOW_US = 1;
  localparam int CORE_RAMP_US = 40;
  // Longest times round down, least times round up; here both are exact.
  localparam logic [15:0] OVERSHOOT_CYC = 16'(OVERSHOOT_US * CLK_MHZ);
  localparam logic [15:0] FULL_PERF_SETTLE_CYC = 16'(FULL_PERF_SETTLE_US * CLK_MHZ);
  localparam logic [15:0] NORMAL_SETTLE_CYC = 16'(NORMAL_SETTLE_US * CLK_MHZ);
  localparam logic [15:0] ENTRY_WINDOW_CYC = 16'(ENTRY_WINDOW_US * CLK_MHZ);
  localparam logic [15:0] CORE_RAMP_CYC = 16'(CORE_RAMP_US * CLK_MHZ);
  // Software wait after wake per core level, in clock cycles.
  localparam logic [6:0] WAKE_WAIT_L0 = 7'h20;
  localparam logic [6:0] WAKE_WAIT_L1 = 7'h30;
  localparam logic [6:0] WAKE_WAIT_L2 = 7'h50;
  localparam logic [6:0] WAKE_WAIT_L3 = 7'h64;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] ADDR_CLK_CTRL = 8'h00;
  localparam logic [7:0] ADDR_LOW_SV_CTRL = 8'h04;
  localparam logic [7:0] ADDR_HIGH_SV_CTRL = 8'h08;
  localparam logic [7:0] ADDR_CORE_LEVEL = 8'h0C;
  localparam logic [7:0] ADDR_LPM_ENTER = 8'h10;
  localparam logic [7:0] ADDR_PM_FLAGS = 8'h14;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h18;
  localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h1C;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h20;
  localparam logic [7:0] ADDR_STATUS = 8'h24;

  // Field positions.
  localparam int CLK_REQ_EN_BIT = 0;
  localparam int CLK_SRC_XTAL_BIT = 1;
  localparam int SV_FULL_PERF_BIT = 0;
  localparam int FLAG_LOW_SETTLE_BIT = 0;
  localparam int FLAG_HIGH_SETTLE_BIT = 1;
  localparam logic [2:0] LPM_CODE_2 = 3'h2;
  localparam logic [2:0] LPM_CODE_3 = 3'h3;
  localparam logic [2:0] LPM_CODE_4 = 3'h4;

  // Interrupt event bits.
  localparam int EV_WAKE_DONE = 0;
  localparam int EV_WAKE_FAIL = 1;
  localparam int EV_CORE_RESET = 2;
  localparam int EV_SETTLED = 3;
  localparam int EV_NUM = 4;

  // Reset values.
  localparam logic [1:0] CLK_CTRL_RST = 2'h1;
  localparam logic SV_FULL_PERF_RST = 1'b0;
  localparam logic [1:0] CORE_LEVEL_RST = 2'h0;

  typedef enum logic [1:0] {
    ST_ACTIVE,
    ST_SLEEP,
    ST_WAKE,
    ST_STUCK
  } lpws_state_e;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } lpws_bus_s;

endpackage : lpws_pkg

// file: logic/lpws_seq.sv
// Low-power wake supervisor: power modes, wake overshoot, supervisor settling and recovery.
//
// What this block does
// - Wake from mode 3 or 4 on internal oscillator overshoots clock up to 6 us.
// - Subsystem clock from internal oscillator is never masked or gated during wake.
// - Low-side supervisor full-performance mode settles in about 2 us.
// - Raising core level in full-performance mode resets the device when settling expires early.
// - Interrupt within 1 us of sleep entry may leave the device stuck asleep.
// - External reset, power cycle or power-up-clear reset recovers a stuck device.
//
// Design decisions made here: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps

module lpws_seq
  import lpws_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic wake_irq,
  input wire logic power_up_clear_reset,
  output logic subsys_clk_run,
  output logic subsys_clk_overshoot,
  output logic subsys_clk_from_xtal,
  output logic sleeping,
  output logic core_reset_req,
  output logic irq
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    lpws_state_e state;
    logic [2:0] lpm;
    logic [1:0] clk_ctrl;
    logic low_full_perf;
    logic high_full_perf;
    logic [1:0] core_level;
    logic low_settle;
    logic high_settle;
    logic [15:0] low_cnt;
    logic [15:0] high_cnt;
    logic ramping;
    logic [15:0] ramp_cnt;
    logic [15:0] state_cnt;
    logic entry_unsettled;
    logic [EV_NUM-1:0] irq_status;
    logic [EV_NUM-1:0] irq_enable;
    logic core_reset;
    logic [31:0] rdata;
  } lpws_st_s;

  lpws_st_s st_q;
  lpws_st_s st_d;
  lpws_bus_s bus;
  logic [EV_NUM-1:0] ev;
  logic [EV_NUM-1:0] clr;
  logic [31:0] rd_mux;
  logic deep;

  assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  // ****************************************************************
  // Read multiplexer
  // ****************************************************************
  always_comb begin
    rd_mux = 32'h0;
    case (bus.addr)
      ADDR_CLK_CTRL: rd_mux = {30'h0, st_q.clk_ctrl};
      ADDR_LOW_SV_CTRL: rd_mux = {31'h0, st_q.low_full_perf};
      ADDR_HIGH_SV_CTRL: rd_mux = {31'h0, st_q.high_full_perf};
      ADDR_CORE_LEVEL: rd_mux = {30'h0, st_q.core_level};
      ADDR_LPM_ENTER: rd_mux = {29'h0, st_q.lpm};
      ADDR_PM_FLAGS: rd_mux = {30'h0, st_q.high_settle, st_q.low_settle};
      ADDR_IRQ_STATUS: rd_mux = {28'h0, st_q.irq_status};
      ADDR_IRQ_ENABLE: rd_mux = {28'h0, st_q.irq_enable};
      ADDR_STATUS: rd_mux = {28'h0, st_q.ramping, st_q.entry_unsettled, st_q.state};
      default: rd_mux = 32'h0;
    endcase
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    st_d = st_q;
    ev = '0;
    clr = '0;
    st_d.core_reset = 1'b0;
    st_d.rdata = bus.rd ? rd_mux : 32'h0;
    deep = (st_q.lpm == LPM_CODE_3) || (st_q.lpm == LPM_CODE_4);

    // Settle counters run down and drop their flag when the count reaches one.
    if (st_q.low_settle) begin
      if (st_q.low_cnt <= 16'h1) begin
        st_d.low_settle = 1'b0;
        ev[EV_SETTLED] = 1'b1;
      end else begin
        st_d.low_cnt = st_q.low_cnt - 16'h1;
      end
    end
    if (st_q.high_settle) begin
      if (st_q.high_cnt <= 16'h1) begin
        st_d.high_settle = 1'b0;
        ev[EV_SETTLED] = 1'b1;
      end else begin
        st_d.high_cnt = st_q.high_cnt - 16'h1;
      end
    end

    // Core voltage ramp; the low-side delay must outlast it or the device resets.
    if (st_q.ramping) begin
      if (st_q.ramp_cnt <= 16'h1) begin
        st_d.ramping = 1'b0;
      end else begin
        st_d.ramp_cnt = st_q.ramp_cnt - 16'h1;
        if (st_q.low_settle && st_q.low_cnt <= 16'h1) begin
          st_d.core_reset = 1'b1;
          ev[EV_CORE_RESET] = 1'b1;
          st_d.ramping = 1'b0;
        end
      end
    end

    // ****************************************************************
    // Register writes
    // ****************************************************************
    if (bus.wr) begin
      case (bus.addr)
        ADDR_CLK_CTRL: st_d.clk_ctrl = bus.wdata[1:0];
        ADDR_LOW_SV_CTRL: begin
          st_d.low_full_perf = bus.wdata[SV_FULL_PERF_BIT];
          st_d.low_settle = 1'b1;
          st_d.low_cnt = bus.wdata[SV_FULL_PERF_BIT] ?
            FULL_PERF_SETTLE_CYC : NORMAL_SETTLE_CYC;
        end
        ADDR_HIGH_SV_CTRL: begin
          st_d.high_full_perf = bus.wdata[SV_FULL_PERF_BIT];
          st_d.high_settle = 1'b1;
          st_d.high_cnt = bus.wdata[SV_FULL_PERF_BIT] ?
            FULL_PERF_SETTLE_CYC : NORMAL_SETTLE_CYC;
        end
        ADDR_CORE_LEVEL: begin
          st_d.core_level = bus.wdata[1:0];
          if (bus.wdata[1:0] > st_q.core_level) begin
            // A raise restarts the low-side comparator delay in the current mode.
            st_d.ramping = 1'b1;
            st_d.ramp_cnt = CORE_RAMP_CYC;
            st_d.low_settle = 1'b1;
            st_d.low_cnt = st_q.low_full_perf ? FULL_PERF_SETTLE_CYC : NORMAL_SETTLE_CYC;
          end
        end
        ADDR_LPM_ENTER: begin
          if (st_q.state == ST_ACTIVE && (bus.wdata[2:0] == LPM_CODE_2 ||
              bus.wdata[2:0] == LPM_CODE_3 || bus.wdata[2:0] == LPM_CODE_4)) begin
            st_d.lpm = bus.wdata[2:0];
            st_d.state = ST_SLEEP;
            st_d.state_cnt = 16'h0;
            // Entry with a supervisor still settling is remembered as hazardous.
            st_d.entry_unsettled = st_q.low_settle | st_q.high_settle;
          end
        end
        ADDR_IRQ_CLEAR: clr = bus.wdata[EV_NUM-1:0];
        ADDR_IRQ_ENABLE: st_d.irq_enable = bus.wdata[EV_NUM-1:0];
        default: ;
      endcase
    end

    // ****************************************************************
    // Power mode sequence
    // ****************************************************************
    case (st_q.state)
      ST_ACTIVE: ;
      ST_SLEEP: begin
        if (st_q.state_cnt != 16'hFFFF) begin
          st_d.state_cnt = st_q.state_cnt + 16'h1;
        end
        if (wake_irq) begin
          // Early interrupt or unsettled entry hangs the wake logic.
          if (st_q.state_cnt < ENTRY_WINDOW_CYC || st_q.entry_unsettled) begin
            st_d.state = ST_STUCK;
            ev[EV_WAKE_FAIL] = 1'b1;
          end else if (deep && !st_q.clk_ctrl[CLK_SRC_XTAL_BIT]) begin
            st_d.state = ST_WAKE;
            st_d.state_cnt = OVERSHOOT_CYC;
          end else begin
            st_d.state = ST_ACTIVE;
            st_d.lpm = 3'h0;
            ev[EV_WAKE_DONE] = 1'b1;
          end
        end
      end
      ST_WAKE: begin
        if (st_q.state_cnt <= 16'h1) begin
          // Software now owes the per-level wait before re-enabling peripherals.
          st_d.state = ST_ACTIVE;
          st_d.lpm = 3'h0;
          ev[EV_WAKE_DONE] = 1'b1;
        end else begin
          st_d.state_cnt = st_q.state_cnt - 16'h1;
        end
      end
      ST_STUCK: ;
      default: st_d.state = ST_ACTIVE;
    endcase

    // A power-up-clear reset brings a stuck device back; settings survive it.
    if (power_up_clear_reset && st_q.state == ST_STUCK) begin
      st_d.state = ST_ACTIVE;
      st_d.lpm = 3'h0;
      st_d.entry_unsettled = 1'b0;
    end

    // Set wins over clear so no event is lost.
    st_d.irq_status = (st_q.irq_status & ~clr) | ev;
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (reset) begin
      // External reset and power cycle both arrive here.
      st_q <= '{state: ST_ACTIVE, lpm: 3'h0, clk_ctrl: CLK_CTRL_RST,
                low_full_perf: SV_FULL_PERF_RST, high_full_perf: SV_FULL_PERF_RST,
                core_level: CORE_LEVEL_RST, low_settle: 1'b0, high_settle: 1'b0,
                low_cnt: 16'h0, high_cnt: 16'h0, ramping: 1'b0, ramp_cnt: 16'h0,
                state_cnt: 16'h0, entry_unsettled: 1'b0, irq_status: '0,
                irq_enable: '0, core_reset: 1'b0, rdata: 32'h0};
    end else begin
      st_q <= st_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // The subsystem clock keeps running through the overshoot; nothing masks it.
  // It stops during deep sleep only when software dropped the request enable, and always while the device is stuck.
  assign subsys_clk_run = !(st_q.state == ST_SLEEP && (st_q.lpm != LPM_CODE_2) &&
                            !st_q.clk_ctrl[CLK_REQ_EN_BIT]) && (st_q.state != ST_STUCK);
  assign subsys_clk_overshoot = (st_q.state == ST_WAKE);
  assign subsys_clk_from_xtal = st_q.clk_ctrl[CLK_SRC_XTAL_BIT];
  assign sleeping = (st_q.state == ST_SLEEP) || (st_q.state == ST_STUCK);
  assign core_reset_req = st_q.core_reset;
  assign reg_rdata = st_q.rdata;
  assign irq = |(st_q.irq_status & st_q.irq_enable);

endmodule : lpws_seq
